// ===== pkg/cbp_cfg.svh
// Constants for the cache bus-priority and coherency block
`ifndef CBP_CFG_SVH
`define CBP_CFG_SVH
`define CBP_SREG_CORE_CFG 10'h3b3
`define CBP_CFG_RESET 32'h00000000
`define CBP_CFG_WMASK 32'h00f30f11
`define CBP_F_STORE_NO_ALLOC 23
`define CBP_F_DATA_PRIO_LOW 22
`define CBP_F_FETCH_PRIO_HI 21
`define CBP_F_FETCH_PRIO_LO 20
`define CBP_F_STORE_EXC_EN 17
`define CBP_F_LOAD_DEBUG 16
`define CBP_F_FETCH_NO_ALLOC 8
`define CBP_F_INFO_SEL 4
`define CBP_F_WAY_SEL 0
`define CBP_LINE_WORDS 8
`define CBP_LAST_BEAT 3'h7
`define CBP_PRIO_LOWEST 2'h0
`define CBP_PRIO_HIGHEST 2'h3
`endif

// ===== pkg/cbp_pkg.sv
// Types for the cache bus-priority and coherency block
package cbp_pkg;
   typedef logic [1:0] cbp_prio_t;
   typedef enum logic [3:0] {
      CBP_IDLE, CBP_LOOKUP, CBP_REREAD, CBP_WT_REQ, CBP_WT_WAIT, CBP_WB_RD,
      CBP_WB_REQ, CBP_WB_WAIT, CBP_FILL_REQ, CBP_FILL_WAIT, CBP_DONE
   } cbp_state_t;
endpackage : cbp_pkg

// ===== hw/cbp_line_mem.sv
// Single-port line data memory with registered read
`timescale 1ns/1ps
module cbp_line_mem #(
   parameter int AW = 7,
   parameter int DW = 32
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [AW-1:0] addr,
   input wire logic we,
   input wire logic [DW-1:0] wdata,
   output logic [DW-1:0] rdata_q
);
   logic [DW-1:0] mem [2**AW];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= mem[addr];
      end
   end
endmodule : cbp_line_mem

// ===== hw/cbp_cache.sv
// Data cache master with core configuration register and fetch priority
`timescale 1ns/1ps
`include "cbp_cfg.svh"
module cbp_cache
   import cbp_pkg::*;
#(
   parameter int IW = 4
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [9:0] sreg_num,
   input wire logic sreg_priv,
   input wire logic sreg_wr,
   input wire logic sreg_rd,
   input wire logic [31:0] sreg_wdata,
   output logic [31:0] sreg_rdata_q,
   output logic priv_fault_q,
   output cbp_prio_t fetch_prio_q,
   output logic fetch_no_allocate_q,
   output logic user_attr_store_exception_enable_q,
   output logic cache_info_select_q,
   output logic cache_way_select_q,
   input wire logic cpu_req,
   input wire logic cpu_we,
   input wire logic cpu_flush,
   input wire logic cpu_wt,
   input wire logic [31:0] cpu_addr,
   input wire logic [31:0] cpu_wdata,
   output logic cpu_ready_q,
   output logic [31:0] cpu_rdata_q,
   output logic busy_q,
   output logic bus_req_q,
   output cbp_prio_t bus_prio_q,
   output logic bus_we_q,
   output logic [31:0] bus_addr_q,
   output logic [31:0] bus_wdata_q,
   input wire logic bus_ack,
   input wire logic [31:0] bus_rdata
);
   localparam int SETS = 2**IW;
   localparam int TW = 32 - IW - 5;

   cbp_state_t state_q;
   logic [31:0] cfg_q;
   logic [31:0] addr_q;
   logic [31:0] wdata_q;
   logic we_q;
   logic wt_q;
   logic flush_q;
   logic [2:0] beat_q;
   logic [TW-1:0] tag_q [SETS];
   logic [SETS-1:0] valid_q;
   logic [SETS-1:0] dirty_q;
   logic [IW+2:0] mem_addr;
   logic mem_we;
   logic [31:0] mem_wdata;
   logic [31:0] mem_rdata;

   // Byte address of one word beat of a line
   function automatic logic [31:0] line_addr(input logic [TW-1:0] t,
                                             input logic [IW-1:0] i,
                                             input logic [2:0] w);
      line_addr = {t, i, w, 2'b00};
   endfunction : line_addr

   wire [IW-1:0] idx = addr_q[IW+4:5];
   wire [2:0] word = addr_q[4:2];
   wire [TW-1:0] tag = addr_q[31:IW+5];
   wire [IW-1:0] cpu_idx = cpu_addr[IW+4:5];
   wire [2:0] cpu_word = cpu_addr[4:2];
   wire hit = valid_q[idx] && (tag_q[idx] == tag);
   wire victim_dirty = valid_q[idx] && dirty_q[idx];
   wire last_beat = (beat_q == `CBP_LAST_BEAT);
   wire no_alloc_store = wt_q || cfg_q[`CBP_F_STORE_NO_ALLOC];
   wire sreg_hit = (sreg_num == `CBP_SREG_CORE_CFG);
   wire sreg_ok = sreg_hit && sreg_priv;
   wire [31:0] cfg_next = (cfg_q & ~`CBP_CFG_WMASK) | (sreg_wdata & `CBP_CFG_WMASK);
   wire [31:0] fill_word = (we_q && beat_q == word) ? wdata_q : bus_rdata;
   // Processor-owned high bit is raised while a dirty victim drains
   wire data_prio_hi = (state_q == CBP_WB_RD);
   wire cbp_prio_t data_prio = {data_prio_hi, cfg_q[`CBP_F_DATA_PRIO_LOW]};

   // Data array port steering
   always_comb begin
      mem_addr = {idx, word};
      mem_we = 1'b0;
      mem_wdata = wdata_q;
      unique case (state_q)
         CBP_IDLE: begin
            mem_addr = {cpu_idx, cpu_word};
         end
         CBP_LOOKUP: begin
            mem_we = !flush_q && we_q && hit;
         end
         CBP_WB_RD: begin
            mem_addr = {idx, beat_q};
         end
         CBP_FILL_WAIT: begin
            // Each acknowledged beat lands in the array
            mem_addr = {idx, beat_q};
            mem_we = bus_ack;
            mem_wdata = fill_word;
         end
         default: begin
         end
      endcase
   end

   cbp_line_mem #(
      .AW(IW + 3),
      .DW(32)
   ) u_mem (
      .clk(clk),
      .arst_n(arst_n),
      .addr(mem_addr),
      .we(mem_we),
      .wdata(mem_wdata),
      .rdata_q(mem_rdata)
   );

   // Core configuration register, privileged access only
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_q <= `CBP_CFG_RESET;
         sreg_rdata_q <= '0;
         priv_fault_q <= 1'b0;
      end else begin
         sreg_rdata_q <= (sreg_rd && sreg_ok) ? cfg_q : '0;
         priv_fault_q <= sreg_hit && !sreg_priv && (sreg_rd || sreg_wr);
         if (sreg_wr && sreg_ok) begin
            cfg_q <= cfg_next;
         end
      end
   end

   // Field outputs follow the register one cycle later
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fetch_prio_q <= `CBP_PRIO_LOWEST;
         fetch_no_allocate_q <= 1'b0;
         user_attr_store_exception_enable_q <= 1'b0;
         cache_info_select_q <= 1'b0;
         cache_way_select_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         fetch_prio_q <= cfg_q[`CBP_F_FETCH_PRIO_HI:`CBP_F_FETCH_PRIO_LO];
         fetch_no_allocate_q <= cfg_q[`CBP_F_FETCH_NO_ALLOC];
         user_attr_store_exception_enable_q <= cfg_q[`CBP_F_STORE_EXC_EN];
         cache_info_select_q <= cfg_q[`CBP_F_INFO_SEL];
         cache_way_select_q <= cfg_q[`CBP_F_WAY_SEL];
         busy_q <= bus_req_q || (state_q != CBP_IDLE && state_q != CBP_DONE);
      end
   end

   // Tag, valid and dirty state per line
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         valid_q <= '0;
         dirty_q <= '0;
         for (int i = 0; i < SETS; i++) begin
            tag_q[i] <= '0;
         end
      end else begin
         unique case (state_q)
            CBP_LOOKUP: begin
               if (flush_q && hit && !dirty_q[idx]) begin
                  valid_q[idx] <= 1'b0;
               end else if (!flush_q && hit && we_q && !wt_q) begin
                  dirty_q[idx] <= 1'b1;
               end
            end
            CBP_WB_WAIT: begin
               if (bus_ack && last_beat) begin
                  dirty_q[idx] <= 1'b0;
                  valid_q[idx] <= !flush_q;
               end
            end
            CBP_FILL_WAIT: begin
               if (bus_ack && last_beat) begin
                  tag_q[idx] <= tag;
                  valid_q[idx] <= 1'b1;
                  dirty_q[idx] <= we_q;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Request sequencer; no snoop path exists for other masters
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= CBP_IDLE;
         addr_q <= '0;
         wdata_q <= '0;
         we_q <= 1'b0;
         wt_q <= 1'b0;
         flush_q <= 1'b0;
         beat_q <= '0;
         cpu_ready_q <= 1'b0;
         cpu_rdata_q <= '0;
         bus_req_q <= 1'b0;
         bus_prio_q <= `CBP_PRIO_LOWEST;
         bus_we_q <= 1'b0;
         bus_addr_q <= '0;
         bus_wdata_q <= '0;
      end else begin
         cpu_ready_q <= 1'b0;
         unique case (state_q)
            CBP_IDLE: begin
               if (cpu_req) begin
                  addr_q <= cpu_addr;
                  wdata_q <= cpu_wdata;
                  we_q <= cpu_we;
                  wt_q <= cpu_wt;
                  flush_q <= cpu_flush;
                  state_q <= CBP_LOOKUP;
               end
            end
            CBP_LOOKUP: begin
               beat_q <= '0;
               if (flush_q) begin
                  state_q <= (hit && dirty_q[idx]) ? CBP_WB_RD : CBP_DONE;
               end else if (hit) begin
                  cpu_rdata_q <= mem_rdata;
                  state_q <= (we_q && wt_q) ? CBP_WT_REQ : CBP_DONE;
               end else if (we_q && no_alloc_store) begin
                  state_q <= CBP_WT_REQ;
               end else if (victim_dirty) begin
                  state_q <= CBP_WB_RD;
               end else begin
                  state_q <= CBP_FILL_REQ;
               end
            end
            CBP_REREAD: begin
               state_q <= CBP_LOOKUP;
            end
            CBP_WT_REQ: begin
               bus_req_q <= 1'b1;
               bus_we_q <= 1'b1;
               bus_prio_q <= data_prio;
               bus_addr_q <= {addr_q[31:2], 2'b00};
               bus_wdata_q <= wdata_q;
               state_q <= CBP_WT_WAIT;
            end
            CBP_WT_WAIT: begin
               if (bus_ack) begin
                  bus_req_q <= 1'b0;
                  state_q <= CBP_DONE;
               end
            end
            CBP_WB_RD: begin
               bus_prio_q <= data_prio;
               state_q <= CBP_WB_REQ;
            end
            CBP_WB_REQ: begin
               bus_req_q <= 1'b1;
               bus_we_q <= 1'b1;
               bus_addr_q <= line_addr(tag_q[idx], idx, beat_q);
               bus_wdata_q <= mem_rdata;
               state_q <= CBP_WB_WAIT;
            end
            CBP_WB_WAIT: begin
               if (bus_ack) begin
                  bus_req_q <= 1'b0;
                  beat_q <= beat_q + 3'h1;
                  if (!last_beat) begin
                     state_q <= CBP_WB_RD;
                  end else begin
                     state_q <= flush_q ? CBP_DONE : CBP_FILL_REQ;
                  end
               end
            end
            CBP_FILL_REQ: begin
               // One single-word request per beat
               bus_req_q <= 1'b1;
               bus_we_q <= 1'b0;
               bus_prio_q <= data_prio;
               bus_addr_q <= line_addr(tag, idx, beat_q);
               state_q <= CBP_FILL_WAIT;
            end
            CBP_FILL_WAIT: begin
               if (bus_ack) begin
                  bus_req_q <= 1'b0;
                  beat_q <= beat_q + 3'h1;
                  if (!last_beat) begin
                     state_q <= CBP_FILL_REQ;
                  end else begin
                     state_q <= we_q ? CBP_DONE : CBP_REREAD;
                  end
               end
            end
            CBP_DONE: begin
               cpu_ready_q <= 1'b1;
               state_q <= CBP_IDLE;
            end
         endcase
      end
   end
endmodule : cbp_cache

// ===== tb/cbp_cache_checker.sv
// Checker for the cache bus priority and configuration register
`timescale 1ns/1ps
`include "cbp_cfg.svh"
module cbp_cache_checker
   import cbp_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [9:0] sreg_num,
   input wire logic sreg_priv,
   input wire logic sreg_wr,
   input wire logic sreg_rd,
   input wire logic [31:0] sreg_wdata,
   input wire logic [31:0] sreg_rdata_q,
   input wire logic priv_fault_q,
   input wire cbp_prio_t fetch_prio_q,
   input wire logic cache_info_select_q,
   input wire logic cache_way_select_q,
   input wire logic bus_req_q,
   input wire cbp_prio_t bus_prio_q,
   input wire logic bus_we_q,
   input wire logic [31:0] bus_addr_q,
   input wire logic bus_ack
);
   logic [31:0] cfg_q;
   wire cfg_sel = sreg_num == `CBP_SREG_CORE_CFG;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_q <= '0;
      end else if (sreg_wr && sreg_priv && cfg_sel) begin
         cfg_q <= sreg_wdata & `CBP_CFG_WMASK;
      end
   end
   a_prio_held: assert property (bus_req_q && !bus_ack |=>
      $stable({bus_prio_q, bus_we_q, bus_addr_q})) else $error("bus request changed");
   a_read_prio: assert property (bus_req_q && !bus_we_q |->
      bus_prio_q == {1'b0, cfg_q[`CBP_F_DATA_PRIO_LOW]}) else $error("read priority wrong");
   a_prio_low_bit: assert property (bus_req_q |->
      bus_prio_q[0] == cfg_q[`CBP_F_DATA_PRIO_LOW]) else $error("data priority low bit wrong");
   a_fetch_prio: assert property (fetch_prio_q ==
      $past(cfg_q[`CBP_F_FETCH_PRIO_HI:`CBP_F_FETCH_PRIO_LO])) else $error("fetch priority wrong");
   a_select_fields: assert property ({cache_info_select_q, cache_way_select_q} ==
      $past({cfg_q[`CBP_F_INFO_SEL], cfg_q[`CBP_F_WAY_SEL]})) else $error("select fields wrong");
   a_sreg_read: assert property (sreg_rd && sreg_priv && cfg_sel |=>
      sreg_rdata_q == $past(cfg_q)) else $error("config read wrong");
   a_priv_fault: assert property ((sreg_wr || sreg_rd) && !sreg_priv && cfg_sel |=>
      priv_fault_q && sreg_rdata_q == 32'h0) else $error("no privilege fault");
   a_other_num: assert property (sreg_rd && !cfg_sel |=>
      sreg_rdata_q == 32'h0 && !priv_fault_q) else $error("other number answered");
   a_req_drop: assert property (bus_req_q && bus_ack |=> !bus_req_q)
      else $error("request held after ack");
endmodule : cbp_cache_checker

bind cbp_cache cbp_cache_checker u_cbp_cache_checker (.clk, .arst_n, .sreg_num, .sreg_priv,
   .sreg_wr, .sreg_rd, .sreg_wdata, .sreg_rdata_q, .priv_fault_q, .fetch_prio_q,
   .cache_info_select_q, .cache_way_select_q, .bus_req_q, .bus_prio_q, .bus_we_q,
   .bus_addr_q, .bus_ack);

// ===== tb/cbp_mem_model.sv
// Word memory answering the cache's bus requests
`timescale 1ns/1ps
module cbp_mem_model (
   input wire logic clk,
   input wire logic [3:0] lat,
   input wire logic bus_req,
   input wire logic bus_we,
   input wire logic [31:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   output logic bus_ack,
   output logic [31:0] bus_rdata
);
   logic [31:0] mem [256];
   logic [3:0] wait_q = 4'h0;
   initial bus_ack = 1'b0;
   initial bus_rdata = 32'h0;
   always @(posedge clk) begin
      bus_ack <= 1'b0;
      bus_rdata <= ~bus_rdata;
      if (!bus_req || bus_ack) begin
         wait_q <= 4'h0;
      end else if (wait_q < lat) begin
         wait_q <= wait_q + 4'h1;
      end else begin
         bus_ack <= 1'b1;
         if (bus_we) begin
            mem[bus_addr[9:2]] <= bus_wdata;
         end else begin
            bus_rdata <= mem[bus_addr[9:2]];
         end
      end
   end
endmodule : cbp_mem_model

// ===== tb/cbp_cache_tb_top.sv
// Bench for the cache master and configuration register
`timescale 1ns/1ps
`include "cbp_cfg.svh"
module cbp_cache_tb_top import cbp_pkg::*;;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [9:0] sreg_num;
   logic sreg_priv, sreg_wr, sreg_rd, cpu_req, cpu_we, cpu_flush, cpu_wt, flt, bsy;
   logic [31:0] sreg_wdata, cpu_addr, cpu_wdata, sreg_rdata_q, cpu_rdata_q, rd;
   logic [31:0] bus_addr_q, bus_wdata_q, bus_rdata;
   logic priv_fault_q, fna, store_exc, info_sel, way_sel, cpu_ready_q, busy_q;
   logic bus_req_q, bus_we_q, bus_ack;
   cbp_prio_t fetch_prio_q, bus_prio_q;
   logic [3:0] lat = 4'h0;
   int error_cnt = 0;
   int total_checks = 0;
   always #2.5 clk = ~clk;
   cbp_cache u_cbp_cache (.clk, .arst_n, .sreg_num, .sreg_priv, .sreg_wr, .sreg_rd,
      .sreg_wdata, .sreg_rdata_q, .priv_fault_q, .fetch_prio_q, .fetch_no_allocate_q(fna),
      .user_attr_store_exception_enable_q(store_exc), .cache_info_select_q(info_sel),
      .cache_way_select_q(way_sel), .cpu_req, .cpu_we, .cpu_flush, .cpu_wt, .cpu_addr,
      .cpu_wdata,
      .cpu_ready_q, .cpu_rdata_q, .busy_q, .bus_req_q, .bus_prio_q, .bus_we_q, .bus_addr_q,
      .bus_wdata_q, .bus_ack, .bus_rdata);
   cbp_mem_model u_cbp_mem_model (.clk, .lat, .bus_req(bus_req_q), .bus_we(bus_we_q),
      .bus_addr(bus_addr_q), .bus_wdata(bus_wdata_q), .bus_ack, .bus_rdata);
   function automatic logic [31:0] mv(logic [31:0] a);
      return 32'h5a000000 | {24'h0, a[9:2]};
   endfunction : mv
   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize
   task automatic sreg(logic wr, logic priv, logic [9:0] num, logic [31:0] d);
      sreg_wr = wr;
      sreg_rd = !wr;
      sreg_priv = priv;
      sreg_num = num;
      sreg_wdata = d;
      @(negedge clk);
      sreg_wr = 1'b0;
      sreg_rd = 1'b0;
      rd = sreg_rdata_q;
      flt = priv_fault_q;
      repeat (2) @(negedge clk);
   endtask : sreg
   task automatic cpu(logic we, logic wt, logic fl, logic [31:0] a, logic [31:0] d);
      int n;
      n = 0;
      bsy = 1'b0;
      cpu_req = 1'b1;
      cpu_we = we;
      cpu_wt = wt;
      cpu_flush = fl;
      cpu_addr = a;
      cpu_wdata = d;
      do begin
         @(negedge clk);
         n++;
         bsy = bsy | busy_q;
      end while (cpu_ready_q !== 1'b1 && n < 600);
      cpu_req = 1'b0;
      rd = cpu_rdata_q;
      if (cpu_ready_q !== 1'b1) begin
         error_cnt++;
         summarize();
      end
      @(negedge clk);
   endtask : cpu
   initial begin
      {sreg_num, sreg_priv, sreg_wr, sreg_rd, sreg_wdata} = '0;
      {cpu_req, cpu_we, cpu_flush, cpu_wt, cpu_addr, cpu_wdata} = '0;
      for (int i = 0; i < 256; i++) u_cbp_mem_model.mem[i] = mv(32'(i) << 2);
      repeat (12) @(negedge clk);
      arst_n = 1'b1;
      sreg(0, 1, `CBP_SREG_CORE_CFG, 0);
      chk("cfg reset", rd, `CBP_CFG_RESET);
      sreg(1, 1, `CBP_SREG_CORE_CFG, '1);
      sreg(1, 0, `CBP_SREG_CORE_CFG, 0);
      chk("fault", {31'h0, flt}, 32'h1);
      sreg(0, 1, `CBP_SREG_CORE_CFG, 0);
      chk("cfg mask", rd, `CBP_CFG_WMASK);
      chk("fields", {26'h0, fetch_prio_q, fna, store_exc, info_sel, way_sel}, 32'h3f);
      sreg(0, 1, 10'h3b2, 0);
      chk("other num", rd, 32'h0);
      for (int p = 0; p < 4; p++) begin
         sreg(1, 1, `CBP_SREG_CORE_CFG, 32'(p) << `CBP_F_FETCH_PRIO_LO);
         chk("fetch prio", {30'h0, fetch_prio_q}, 32'(p));
      end
      $display("test registers done");
      cpu(1, 0, 0, 32'h104, 32'h55);
      chk("mem kept", u_cbp_mem_model.mem[8'h41], mv(32'h104));
      cpu(0, 0, 0, 32'h108, 0);
      chk("line fill", rd, mv(32'h108));
      u_cbp_mem_model.mem[8'h42] = 32'hee;
      cpu(0, 0, 0, 32'h108, 0);
      chk("no snoop", rd, mv(32'h108));
      cpu(0, 0, 0, 32'h104, 0);
      chk("merged", rd, 32'h55);
      $display("test store miss done");
      sreg(1, 1, `CBP_SREG_CORE_CFG, 32'h1 << `CBP_F_DATA_PRIO_LOW);
      lat = 4'h3;
      cpu(0, 0, 0, 32'h304, 0);
      chk("reload", rd, mv(32'h304));
      chk("busy", {30'h0, bsy, busy_q}, 32'h2);
      chk("wb store", u_cbp_mem_model.mem[8'h41], 32'h55);
      chk("wb full", u_cbp_mem_model.mem[8'h42], mv(32'h108));
      cpu(1, 0, 0, 32'h300, 32'h77);
      chk("wb hold", u_cbp_mem_model.mem[8'hc0], mv(32'h300));
      cpu(0, 0, 1, 32'h300, 0);
      chk("flush", u_cbp_mem_model.mem[8'hc0], 32'h77);
      $display("test victim done");
      lat = 4'h0;
      cpu(0, 0, 0, 32'h140, 0);
      cpu(1, 1, 0, 32'h144, 32'h99);
      chk("wt mem", u_cbp_mem_model.mem[8'h51], 32'h99);
      cpu(0, 0, 0, 32'h144, 0);
      chk("wt cache", rd, 32'h99);
      u_cbp_mem_model.mem[8'h51] = 32'h11;
      cpu(0, 0, 1, 32'h140, 0);
      chk("wt clean", u_cbp_mem_model.mem[8'h51], 32'h11);
      cpu(0, 0, 0, 32'h144, 0);
      chk("refetch", rd, 32'h11);
      $display("test write through done");
      summarize();
   end
endmodule : cbp_cache_tb_top
